// >>> rtl/homing_pkg.sv
// Constants and types shared by the homing sequencer and its step generator.
package homing_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int SPEED_W = 20;
  localparam int OFFSET_W = 24;
  localparam int ACC_W = 26;
  localparam int TICK_W = 16;
  localparam logic [OFFSET_W-1:0] BACKOFF_STEPS = 24'h0000C8;
  localparam logic [SPEED_W-1:0] APPROACH_CAP_HZ = 20'h001F4;
  localparam int RAMP_TICK_US = 1000;
  localparam int RAMP_TICK_CYCLES = (CLK_HZ / 1_000_000) * RAMP_TICK_US;
  localparam logic [TICK_W-1:0] RAMP_TICK_LAST =
    TICK_W'(RAMP_TICK_CYCLES - 1);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);
  localparam logic [1:0] MODE_TWO_SENSOR = 2'h0;
  localparam logic [1:0] MODE_THREE_SENSOR = 2'h1;
  localparam logic [1:0] MODE_PUSH = 2'h2;
  // Sensor and home request index within the synchroniser vector.
  localparam int S_HOME = 0;
  localparam int S_POS = 1;
  localparam int S_NEG = 2;
  localparam int S_SLOT = 3;
  localparam int S_PHASE = 4;
  localparam int S_REQ = 5;
  localparam int SYNC_W = 6;
  typedef enum logic [3:0] {
    ST_IDLE, ST_SEEK, ST_REVERSE, ST_APPROACH, ST_ESCAPE, ST_BACKOFF,
    ST_RESUME, ST_OFFSET_START, ST_OFFSET, ST_HALT, ST_DONE
  } seq_state_t;
endpackage

// >>> rtl/motion_if.sv
// Link between the homing sequencer and the step generator.
`timescale 1ns/1ps
`default_nettype none
interface motion_if;
  logic                              run;
  logic [homing_pkg::SPEED_W-1:0]    target_speed;
  logic [homing_pkg::SPEED_W-1:0]    start_speed;
  logic [homing_pkg::SPEED_W-1:0]    accel;
  logic                              step;
  logic                              moving;
  modport seq (output run, target_speed, start_speed, accel,
               input step, moving);
  modport gen (input run, target_speed, start_speed, accel,
               output step, moving);
endinterface
`default_nettype wire

// >>> rtl/step_profile.sv
// Step pulse generator with a linear speed ramp.
`timescale 1ns/1ps
`default_nettype none
module step_profile (
  input  wire logic  core_clk,
  input  wire logic  reset,
  input  wire logic  clk_en,
  motion_if.gen      mif
);
  logic [homing_pkg::SPEED_W-1:0] speed;
  logic [homing_pkg::ACC_W-1:0]   acc;
  logic [homing_pkg::TICK_W-1:0]  tick;
  logic                           tick_done;
  logic [homing_pkg::ACC_W-1:0]   acc_sum;

  // Moves cur toward goal by rate, never below floor.
  function automatic logic [homing_pkg::SPEED_W-1:0] step_toward(
    input logic [homing_pkg::SPEED_W-1:0] cur,
    input logic [homing_pkg::SPEED_W-1:0] goal,
    input logic [homing_pkg::SPEED_W-1:0] rate,
    input logic [homing_pkg::SPEED_W-1:0] floor_v);
    logic [homing_pkg::SPEED_W:0] up;
    logic [homing_pkg::SPEED_W:0] dn;
    logic [homing_pkg::SPEED_W-1:0] res;
    up = {1'b0, cur} + {1'b0, rate};
    dn = {1'b0, cur} - {1'b0, rate};
    if (cur < goal) begin
      res = (up > {1'b0, goal}) ? goal : up[homing_pkg::SPEED_W-1:0];
    end else if (dn[homing_pkg::SPEED_W] || dn < {1'b0, goal}) begin
      res = goal;
    end else begin
      res = dn[homing_pkg::SPEED_W-1:0];
    end
    if (res < floor_v) begin
      res = floor_v;
    end
    return res;
  endfunction

  assign tick_done = (tick == homing_pkg::RAMP_TICK_LAST);
  assign acc_sum = acc + homing_pkg::ACC_W'(speed);

  // Ramp interval timer, counting only while moving.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick <= '0;
    end else if (clk_en) begin
      if (!mif.moving || tick_done) begin
        tick <= '0;
      end else begin
        tick <= tick + 1'b1;
      end
    end
  end

  // Speed profile: jump to the lower of start and target speed, ramp to target, ramp down to stop.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      speed <= '0;
      mif.moving <= 1'b0;
    end else if (clk_en) begin
      if (!mif.moving) begin
        if (mif.run) begin
          // Never start above the target, so a slow approach starts slow.
          speed <= (mif.target_speed < mif.start_speed)
                   ? mif.target_speed : mif.start_speed; // R1
          mif.moving <= 1'b1;
        end
      end else if (mif.run) begin
        if (tick_done) begin
          speed <= step_toward(speed, mif.target_speed, mif.accel,
                               '0);
        end
      end else if (speed <= mif.start_speed) begin
        mif.moving <= 1'b0;
      end else if (tick_done) begin
        speed <= step_toward(speed, mif.start_speed, mif.accel,
                             mif.start_speed); // R5
      end
    end
  end

  // Phase accumulator that emits one step per CLK_HZ of accumulated speed.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      acc <= '0;
      mif.step <= 1'b0;
    end else if (clk_en) begin
      if (!mif.moving) begin
        acc <= '0;
        mif.step <= 1'b0;
      end else if (acc_sum >= homing_pkg::ACC_WRAP) begin
        acc <= acc_sum - homing_pkg::ACC_WRAP;
        mif.step <= 1'b1;
      end else begin
        acc <= acc_sum;
        mif.step <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/stepper_homing_sequencer.sv
// Return-to-home sequencer for a stepper driver.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (R1) Final approach speed is the start speed below 500 Hz, else 500 Hz.
// (R2) In 3-sensor mode with extras enabled, travel goes on past home edge.
// (R3) That travel ends only on an extra signal while home is still active.
// (R4) Homing works from the home sensor alone in either start direction.
// (R5) After the home edge the motor ramps down at the homing rate.
// (R6) In 2-sensor mode, once clear of the limit, it moves exactly 200 steps.
// (R7) In 2-sensor mode a limit reverses travel until that limit clears.
// (R8) In 2-sensor mode with extras, it pauses, resumes, ends on the extra.
// (R9) Mode encoding is 0 two-sensor, 1 three-sensor, 2 push.
// (R10) The 200 steps are motor steps, independent of resolution.
// (R11) Home complete is raised when the sequence has finished.
// (R12) A nonzero offset adds a positioning move whose end is the home.
module stepper_homing_sequencer (
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  input  wire logic                          home_request,
  input  wire logic [1:0]                    homing_mode,
  input  wire logic                          start_dir_positive,
  input  wire logic                          slot_detect_enable,
  input  wire logic                          phase_detect_enable,
  input  wire logic [homing_pkg::SPEED_W-1:0] start_speed,
  input  wire logic [homing_pkg::SPEED_W-1:0] seek_speed,
  input  wire logic [homing_pkg::SPEED_W-1:0] homing_accel,
  input  wire logic [homing_pkg::OFFSET_W-1:0] home_offset,
  input  wire logic                          home_sensor,
  input  wire logic                          positive_limit_sensor,
  input  wire logic                          negative_limit_sensor,
  input  wire logic                          disc_slot_sensor,
  input  wire logic                          excitation_phase_marker,
  output logic                               step_out,
  output logic                               dir_positive,
  output logic                               busy,
  output logic                               home_complete,
  output logic [homing_pkg::SPEED_W-1:0]     final_approach_speed
);
  motion_if mif ();

  logic [homing_pkg::SYNC_W-1:0]   sens_meta;
  logic [homing_pkg::SYNC_W-1:0]   sens_sync;
  logic [homing_pkg::SYNC_W-1:0]   sens_prev;
  logic [homing_pkg::SYNC_W-1:0]   sens_rise;
  homing_pkg::seq_state_t          state;
  homing_pkg::seq_state_t          after_halt;
  logic [homing_pkg::OFFSET_W-1:0] step_count;
  logic [homing_pkg::OFFSET_W-1:0] step_goal;
  logic                            extras_on;
  logic                            extra_hit;
  logic                            limit_ahead;
  logic                            escape_from_pos;
  logic [homing_pkg::SPEED_W-1:0]  approach_speed;

  // Magnitude of a signed step count.
  function automatic logic [homing_pkg::OFFSET_W-1:0] abs_steps(
    input logic [homing_pkg::OFFSET_W-1:0] v);
    return v[homing_pkg::OFFSET_W-1] ? (~v + 1'b1) : v;
  endfunction

  step_profile u_profile (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .mif      (mif)
  );

  // Two-stage synchronisers for the sensor pins and home request, plus a delayed copy for edges.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sens_meta <= '0;
      sens_sync <= '0;
      sens_prev <= '0;
    end else if (clk_en) begin
      sens_meta <= {home_request, excitation_phase_marker, disc_slot_sensor,
                    negative_limit_sensor, positive_limit_sensor,
                    home_sensor};
      sens_sync <= sens_meta;
      sens_prev <= sens_sync;
    end
  end

  assign sens_rise = sens_sync & ~sens_prev;
  assign extras_on = slot_detect_enable | phase_detect_enable;
  assign extra_hit = (slot_detect_enable & sens_rise[homing_pkg::S_SLOT])
                   | (phase_detect_enable & sens_rise[homing_pkg::S_PHASE]);
  // Only the limit in the direction of travel counts.
  assign limit_ahead = dir_positive ? sens_sync[homing_pkg::S_POS]
                                    : sens_sync[homing_pkg::S_NEG];
  assign approach_speed = (start_speed < homing_pkg::APPROACH_CAP_HZ)
                        ? start_speed : homing_pkg::APPROACH_CAP_HZ; // R1

  // Profile settings that stay constant during a sequence.
  assign mif.start_speed = start_speed;
  assign mif.accel = homing_accel;

  // Final approach speed shown to the outside.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      final_approach_speed <= '0;
      step_out <= 1'b0;
    end else if (clk_en) begin
      final_approach_speed <= approach_speed; // R1
      step_out <= mif.step;
    end
  end

  // Step counter for fixed-length moves; cleared whenever a move is armed.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      step_count <= '0;
    end else if (clk_en) begin
      if (state != homing_pkg::ST_BACKOFF &&
          state != homing_pkg::ST_OFFSET) begin
        step_count <= '0;
      end else if (mif.step) begin
        step_count <= step_count + 1'b1; // R10
      end
    end
  end

  // Main sequence.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= homing_pkg::ST_IDLE;
      after_halt <= homing_pkg::ST_IDLE;
      mif.run <= 1'b0;
      mif.target_speed <= '0;
      dir_positive <= 1'b1;
      busy <= 1'b0;
      home_complete <= 1'b0;
      escape_from_pos <= 1'b0;
      step_goal <= '0;
    end else if (clk_en) begin
      case (state)
        homing_pkg::ST_IDLE: begin
          if (sens_rise[homing_pkg::S_REQ] &&
              (homing_mode == homing_pkg::MODE_TWO_SENSOR ||
               homing_mode == homing_pkg::MODE_THREE_SENSOR)) begin // R9
            dir_positive <= start_dir_positive; // R4
            busy <= 1'b1;
            home_complete <= 1'b0;
            mif.run <= 1'b1;
            mif.target_speed <=
              (homing_mode == homing_pkg::MODE_THREE_SENSOR)
              ? seek_speed : start_speed;
            state <= homing_pkg::ST_SEEK;
          end
        end
        homing_pkg::ST_SEEK: begin
          if (limit_ahead) begin
            escape_from_pos <= dir_positive;
            mif.run <= 1'b0;
            after_halt <= homing_pkg::ST_REVERSE;
            state <= homing_pkg::ST_HALT;
          end else if (homing_mode == homing_pkg::MODE_THREE_SENSOR &&
                       sens_rise[homing_pkg::S_HOME]) begin
            if (extras_on) begin
              mif.target_speed <= approach_speed; // R2
              state <= homing_pkg::ST_APPROACH;
            end else begin
              mif.run <= 1'b0; // R5
              after_halt <= homing_pkg::ST_OFFSET_START;
              state <= homing_pkg::ST_HALT;
            end
          end
        end
        homing_pkg::ST_REVERSE: begin
          dir_positive <= ~dir_positive; // R7
          mif.run <= 1'b1;
          state <= (homing_mode == homing_pkg::MODE_TWO_SENSOR)
                   ? homing_pkg::ST_ESCAPE : homing_pkg::ST_SEEK;
        end
        homing_pkg::ST_ESCAPE: begin
          if (!(escape_from_pos ? sens_sync[homing_pkg::S_POS]
                                : sens_sync[homing_pkg::S_NEG])) begin
            step_goal <= homing_pkg::BACKOFF_STEPS; // R6
            state <= homing_pkg::ST_BACKOFF; // R7
          end
        end
        homing_pkg::ST_BACKOFF: begin
          if (mif.step && step_count == step_goal - 1'b1) begin
            mif.run <= 1'b0; // R6
            after_halt <= extras_on ? homing_pkg::ST_RESUME
                                    : homing_pkg::ST_OFFSET_START;
            state <= homing_pkg::ST_HALT;
          end
        end
        homing_pkg::ST_RESUME: begin
          mif.target_speed <= approach_speed; // R8
          mif.run <= 1'b1;
          state <= homing_pkg::ST_APPROACH;
        end
        homing_pkg::ST_APPROACH: begin
          if (extra_hit && (homing_mode == homing_pkg::MODE_TWO_SENSOR ||
                            sens_sync[homing_pkg::S_HOME])) begin // R3
            mif.run <= 1'b0; // R8
            after_halt <= homing_pkg::ST_OFFSET_START;
            state <= homing_pkg::ST_HALT;
          end
        end
        homing_pkg::ST_OFFSET_START: begin
          if (home_offset != '0) begin
            dir_positive <= ~home_offset[homing_pkg::OFFSET_W-1]; // R12
            step_goal <= abs_steps(home_offset);
            mif.target_speed <= start_speed;
            mif.run <= 1'b1;
            state <= homing_pkg::ST_OFFSET;
          end else begin
            state <= homing_pkg::ST_DONE;
          end
        end
        homing_pkg::ST_OFFSET: begin
          if (mif.step && step_count == step_goal - 1'b1) begin
            mif.run <= 1'b0; // R12
            after_halt <= homing_pkg::ST_DONE;
            state <= homing_pkg::ST_HALT;
          end
        end
        homing_pkg::ST_HALT: begin
          if (!mif.moving) begin
            state <= after_halt;
          end
        end
        homing_pkg::ST_DONE: begin
          busy <= 1'b0;
          home_complete <= 1'b1; // R11
          state <= homing_pkg::ST_IDLE;
        end
        default: begin
          state <= homing_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> testbench/axis_sensor_model.sv
// Axis model: carriage position from step pulses, and its sensors.
`timescale 1ns/1ps
`default_nettype none
module axis_sensor_model (
  input  wire logic core_clk,
  input  wire logic step_out,
  input  wire logic dir_positive,
  input  wire logic limits_fitted,
  input  wire logic load,
  input  var  int   load_pos,
  output var  int   pos,
  output logic      home_sensor,
  output logic      positive_limit_sensor,
  output logic      negative_limit_sensor
);
  // Each step moves the carriage; a rotary axis wraps at 1024.
  always @(posedge core_clk) begin
    if (load) begin
      pos <= load_pos;
    end else if (step_out) begin
      pos <= (pos + (dir_positive ? 1 : 1023)) % 1024;
    end
  end
  // Active-high sensors; limits that are not fitted read inactive.
  assign home_sensor = (pos >= 500) && (pos < 800);
  assign positive_limit_sensor = limits_fitted && (pos >= 900);
  assign negative_limit_sensor = limits_fitted && (pos <= 100);
endmodule
`default_nettype wire

// >>> testbench/stepper_homing_sequencer_chk.sv
// Port-level checker for the homing sequencer.
`timescale 1ns/1ps
`default_nettype none
module homing_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        home_request,
  input wire logic [1:0]  homing_mode,
  input wire logic        start_dir_positive,
  input wire logic [19:0] start_speed,
  input wire logic        positive_limit_sensor,
  input wire logic        step_out,
  input wire logic        dir_positive,
  input wire logic        busy,
  input wire logic        home_complete,
  input wire logic [19:0] final_approach_speed
);
  // All checks use the core clock and rest during reset.
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // The approach speed register tracks the capped start speed.
  property p_cap;
    $past(clk_en) && !$past(reset) |-> final_approach_speed ==
      (($past(start_speed) < homing_pkg::APPROACH_CAP_HZ) ?
       $past(start_speed) : homing_pkg::APPROACH_CAP_HZ);
  endproperty
  a_cap: assert property (p_cap) else $error("approach speed wrong");
  // Only the two sensor modes start, and a request starts them promptly.
  property p_mode;
    $rose(busy) |-> $past(homing_mode) < 2'h2;
  endproperty
  a_mode: assert property (p_mode) else $error("bad mode ran");
  property p_start;
    $rose(home_request) && !busy && homing_mode < 2'h2 && clk_en
      |-> ##[2:4] busy;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_dir;
    $rose(busy) |-> dir_positive == $past(start_dir_positive);
  endproperty
  a_dir: assert property (p_dir) else $error("wrong start dir");
  // Done is cleared at start, raised as busy drops, and steps need a run.
  property p_clear;
    $rose(busy) |-> !home_complete;
  endproperty
  a_clear: assert property (p_clear) else $error("done at start");
  property p_done;
    $fell(busy) |-> home_complete;
  endproperty
  a_done: assert property (p_done) else $error("no done at end");
  property p_step;
    step_out |-> busy || $past(busy);
  endproperty
  a_step: assert property (p_step) else $error("step while idle");
  // In two-sensor mode a held positive limit turns the travel round.
  property p_rev;
    (busy && homing_mode == 2'h0 && dir_positive && positive_limit_sensor)
      [*4] |-> ##[0:400] !dir_positive;
  endproperty
  a_rev: assert property (p_rev) else $error("limit not reversed");
endmodule
bind stepper_homing_sequencer homing_chk u_chk (
  .core_clk              (core_clk),
  .reset                 (reset),
  .clk_en                (clk_en),
  .home_request          (home_request),
  .homing_mode           (homing_mode),
  .start_dir_positive    (start_dir_positive),
  .start_speed           (start_speed),
  .positive_limit_sensor (positive_limit_sensor),
  .step_out              (step_out),
  .dir_positive          (dir_positive),
  .busy                  (busy),
  .home_complete         (home_complete),
  .final_approach_speed  (final_approach_speed)
);
`default_nettype wire

// >>> testbench/stepper_homing_sequencer_tb.sv
// Self-checking bench for the homing sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  fails++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", \
  $time, got, exp); end end
module stepper_homing_sequencer_tb;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        home_request = 1'b0;
  logic [1:0]  homing_mode = 2'h1;
  logic        start_dir_positive = 1'b1;
  logic        slot_detect_enable = 1'b0;
  logic        phase_detect_enable = 1'b0;
  logic [19:0] start_speed = 20'hF4240;
  logic [19:0] seek_speed = 20'hF4240;
  logic [19:0] homing_accel = 20'hF4240;
  logic [23:0] home_offset = 24'h000000;
  logic        disc_slot_sensor = 1'b0;
  logic        excitation_phase_marker = 1'b0;
  logic        limits_fitted = 1'b0;
  logic        load = 1'b0;
  logic [19:0] cap = homing_pkg::APPROACH_CAP_HZ;
  logic [19:0] caps [3] = '{20'h001F3, 20'h001F4, 20'hF4240};
  int          load_pos = 0;
  int          pos, n, back_steps = 0, fails = 0, checks = 0;
  logic        home_sensor, positive_limit_sensor, negative_limit_sensor;
  logic        step_out, dir_positive, busy, home_complete;
  logic [19:0] final_approach_speed;
  // The design, and the axis that it home_sensor.
  stepper_homing_sequencer uut (
    .core_clk                (core_clk),
    .reset                   (reset),
    .clk_en                  (1'b1),
    .home_request            (home_request),
    .homing_mode             (homing_mode),
    .start_dir_positive      (start_dir_positive),
    .slot_detect_enable      (slot_detect_enable),
    .phase_detect_enable     (phase_detect_enable),
    .start_speed             (start_speed),
    .seek_speed              (seek_speed),
    .homing_accel            (homing_accel),
    .home_offset             (home_offset),
    .home_sensor             (home_sensor),
    .positive_limit_sensor   (positive_limit_sensor),
    .negative_limit_sensor   (negative_limit_sensor),
    .disc_slot_sensor        (disc_slot_sensor),
    .excitation_phase_marker (excitation_phase_marker),
    .step_out                (step_out),
    .dir_positive            (dir_positive),
    .busy                    (busy),
    .home_complete           (home_complete),
    .final_approach_speed    (final_approach_speed)
  );
  axis_sensor_model model (
    .core_clk              (core_clk),
    .step_out              (step_out),
    .dir_positive          (dir_positive),
    .limits_fitted         (limits_fitted),
    .load                  (load),
    .load_pos              (load_pos),
    .pos                   (pos),
    .home_sensor           (home_sensor),
    .positive_limit_sensor (positive_limit_sensor),
    .negative_limit_sensor (negative_limit_sensor)
  );
  // A 40 MHz clock, and a count of negative steps within a run.
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (load) back_steps <= 0;
    else if (step_out && !dir_positive) back_steps <= back_steps + 1;
  end
  // Places the carriage, requests a run and waits for it to start.
  task automatic go(input int p, input logic [1:0] m, input logic d,
                    input logic lim);
    @(negedge core_clk);
    load_pos = p;
    load = 1'b1;
    homing_mode = m;
    start_dir_positive = d;
    limits_fitted = lim;
    @(negedge core_clk);
    load = 1'b0;
    home_request = 1'b1;
    for (n = 0; busy !== 1'b1 && n < 8; n++) @(negedge core_clk);
    home_request = 1'b0;
    `CHK(busy, 1'b1)
  endtask
  // Waits a bounded time for the run to end.
  task automatic finish();
    for (n = 0; busy === 1'b1 && n < 30000; n++) @(negedge core_clk);
    @(negedge core_clk);
    `CHK(home_complete, 1'b1)
  endtask
  // Pulses the slot sensor (0) or the phase marker (1).
  task automatic pulse(input int i);
    @(negedge core_clk);
    if (i) excitation_phase_marker = 1'b1;
    else disc_slot_sensor = 1'b1;
    repeat (4) @(negedge core_clk);
    disc_slot_sensor = 1'b0;
    excitation_phase_marker = 1'b0;
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    print_verdict();
  end
  // Test sequence.
  initial begin
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    foreach (caps[i]) begin
      start_speed = caps[i];
      repeat (2) @(negedge core_clk);
      `CHK(final_approach_speed, (caps[i] < cap) ? caps[i] : cap)
    end
    start_speed = 20'hF4240;
    $display("test approach_cap done");
    for (int m = 2; m < 4; m++) begin
      homing_mode = m[1:0];
      home_request = 1'b1;
      repeat (8) @(negedge core_clk);
      `CHK(busy, 1'b0)
      home_request = 1'b0;
      repeat (4) @(negedge core_clk);
    end
    $display("test refused_modes done");
    for (int d = 1; d >= 0; d--) begin
      go(d ? 300 : 900, 2'h1, d[0], 1'b0);
      finish();
      `CHK(home_sensor, 1'b1)
      `CHK(dir_positive, d[0])
    end
    $display("test home_only done");
    home_offset = 24'hFFFFFB;
    go(300, 2'h1, 1'b1, 1'b0);
    finish();
    `CHK(back_steps, 5)
    `CHK(pos, 495)
    home_offset = 24'h000000;
    $display("test offset done");
    for (int d = 1; d >= 0; d--) begin
      go(d ? 700 : 300, 2'h0, d[0], 1'b1);
      finish();
      `CHK(pos, d ? 699 : 301)
      `CHK(dir_positive, !d[0])
    end
    $display("test two_sensor done");
    slot_detect_enable = 1'b1;
    go(700, 2'h0, 1'b1, 1'b1);
    for (n = 0; pos != 699 && n < 20000; n++) @(negedge core_clk);
    `CHK(pos, 699)
    repeat (200) @(negedge core_clk);
    `CHK(busy, 1'b1)
    pulse(0);
    finish();
    $display("test two_sensor_extra done");
    for (int i = 0; i < 2; i++) begin
      {slot_detect_enable, phase_detect_enable} = i ? 2'b01 : 2'b10;
      go(300, 2'h1, 1'b1, 1'b0);
      pulse(i);
      `CHK(busy, 1'b1)
      for (n = 0; home_sensor !== 1'b1 && n < 60000; n++) @(negedge core_clk);
      repeat (8) @(negedge core_clk);
      `CHK(busy, 1'b1)
      pulse(i);
      finish();
      `CHK(home_sensor, 1'b1)
    end
    $display("test three_sensor_extra done");
    print_verdict();
  end
endmodule
`default_nettype wire
